// File: inc/dcd_pkg.sv
/*
 * dcd_pkg: link geometry, timing counts, reset values, command and power-state
 * types and the bank and burst helpers shared by both ends of the command link.
 * Assumes each end runs from one 40 MHz reference clock.
 */
package dcd_pkg;
	// ---------------------------------------------------------------
	// link geometry
	// ---------------------------------------------------------------
	localparam int BG_W       = 2;
	localparam int BA_W       = 2;
	localparam int ADDR_W     = 14;
	localparam int ROW_W      = 18;
	localparam int COL_W      = 10;
	localparam int BANK_IDX_W = BG_W + BA_W;
	localparam int NBANK      = 1 << BANK_IDX_W;
	localparam int AP_BIT     = 10;
	localparam int BC_BIT     = 12;
	localparam int MR_SEL_W   = 3;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int REF_CLK_KHZ = 40000;
	localparam int T_CK_NS     = 200;
	localparam int CK_DIV_CYC  = T_CK_NS * REF_CLK_KHZ / 1000000;
	localparam logic [3:0] BURST_CK_BL8 = 4'h4;
	localparam logic [3:0] BURST_CK_BC4 = 4'h2;

	// ---------------------------------------------------------------
	// burst mode and reset values
	// ---------------------------------------------------------------
	localparam logic [MR_SEL_W-1:0] MR_BURST = 3'h0;
	localparam logic [1:0] BM_FIXED8   = 2'h0;
	localparam logic [1:0] BM_OTF      = 2'h1;
	localparam logic [1:0] BM_FIXED4   = 2'h2;
	localparam logic [1:0] BM_RST      = BM_FIXED8;
	localparam logic       CKE_RST     = 1'h1;
	localparam logic       RESET_N_RST = 1'h0;

	typedef enum logic [4:0] {
		CMD_DES, CMD_NOP, CMD_MRS, CMD_REF, CMD_SRE, CMD_SRX, CMD_PDE, CMD_PDX,
		CMD_PRE, CMD_PREA, CMD_ACT, CMD_WR, CMD_WRA, CMD_RD, CMD_RDA,
		CMD_ZQCL, CMD_ZQCS, CMD_RFU
	} dcd_cmd_t;

	typedef enum logic [1:0] {PWR_ON, PWR_DOWN, PWR_SELF} dcd_pwr_t;

	// open-bank map after one command; anything else leaves it alone
	function automatic logic [NBANK-1:0] bank_update(
		input logic [NBANK-1:0]      open,
		input dcd_cmd_t              c,
		input logic [BANK_IDX_W-1:0] idx
	);
		logic [NBANK-1:0] one;
		one = {{(NBANK-1){1'h0}}, 1'h1} << idx;
		case (c)
			CMD_ACT:                   bank_update = open | one;
			CMD_PRE, CMD_RDA, CMD_WRA: bank_update = open & ~one;
			CMD_PREA:                  bank_update = '0;
			default:                   bank_update = open;
		endcase
	endfunction

	// link clock cycles that one burst keeps the data bus
	function automatic logic [3:0] burst_ck(input logic bc4);
		burst_ck = bc4 ? BURST_CK_BC4 : BURST_CK_BL8;
	endfunction
endpackage

// File: inc/dcd_link_if.sv
/*
 * dcd_link_if: command, address and control pins between controller and device.
 * Assumes the controller end drives every signal and the device end only reads.
 */
`timescale 1ns/1ps
interface dcd_link_if;
	import dcd_pkg::*;

	logic              ck;
	logic              reset_n;
	logic              cke;
	logic              cs_n;
	logic              act_n;
	logic              ras_n_a16;
	logic              cas_n_a15;
	logic              we_n_a14;
	logic [BG_W-1:0]   bg;
	logic [BA_W-1:0]   ba;
	logic              a17;
	logic [ADDR_W-1:0] addr;
	logic              odt;

	modport ctrl (output ck, reset_n, cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14,
		bg, ba, a17, addr, odt);
	modport dram (input ck, reset_n, cke, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14,
		bg, ba, a17, addr, odt);
endinterface

// File: hw/dcd_ctrl.sv
/*
 * dcd_ctrl: controller end of the command link. Divides ref_clk into the link
 * clock and places one command per link cycle, changing pins on the falling edge.
 * Assumes the user holds a request stable until it is taken or refused.
 */
`timescale 1ns/1ps
module dcd_ctrl
	import dcd_pkg::*;
#(
	parameter int CK_DIV = CK_DIV_CYC
)
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             srst,
	// link to device
	dcd_link_if.ctrl              link,
	// command request
	input  wire logic             req_valid,
	input  wire dcd_cmd_t         req_cmd,
	input  wire logic [BG_W-1:0]  req_bg,
	input  wire logic [BA_W-1:0]  req_ba,
	input  wire logic [ROW_W-1:0] req_addr,
	input  wire logic             req_bc4,
	input  wire logic             nop_permit,
	input  wire logic             odt_req,
	input  wire logic             dram_reset_req,
	// answer and state
	output logic                  req_taken,
	output logic                  req_refused,
	output dcd_pwr_t              pwr_state,
	output logic [NBANK-1:0]      bank_open
);
	// ---------------------------------------------------------------
	// link clock divider
	// ---------------------------------------------------------------
	localparam logic [7:0] HALF_M1 = 8'(CK_DIV / 2 - 1);

	logic [7:0] div_cnt;
	logic       tick;
	assign tick = (div_cnt == HALF_M1) && link.ck;

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			div_cnt <= 8'h0;
			link.ck <= 1'h0;
		end
		else if (div_cnt == HALF_M1)
		begin
			div_cnt <= 8'h0;
			link.ck <= ~link.ck;
		end
		else
			div_cnt <= div_cnt + 8'h1;
	end

	// ---------------------------------------------------------------
	// request checking and encoding
	// ---------------------------------------------------------------
	logic       gap;
	logic [3:0] burst_cnt;
	logic       on_ok;
	logic       all_idle;
	logic       ok;
	logic       take;
	logic       is_burst;
	logic       cke_cmd;
	logic       deselect;
	logic       ap;
	logic [3:0] enc;
	logic [ADDR_W-1:0] addr_cmd;

	assign on_ok    = (pwr_state == PWR_ON) && !gap;
	assign all_idle = (bank_open == '0) && (burst_cnt == 4'h0);
	assign is_burst = req_cmd inside {CMD_WR, CMD_WRA, CMD_RD, CMD_RDA};
	assign cke_cmd  = req_cmd inside {CMD_PDE, CMD_PDX, CMD_SRE, CMD_SRX};
	assign deselect = req_cmd inside {CMD_PDE, CMD_PDX, CMD_SRX};
	assign take     = tick && req_valid && ok;
	assign ap       = req_cmd inside {CMD_PREA, CMD_RDA, CMD_WRA, CMD_ZQCL};

	function automatic logic cmd_ok(input dcd_cmd_t c);
		case (c)
			CMD_SRE:                           cmd_ok = on_ok && all_idle;
			CMD_PDX:                           cmd_ok = (pwr_state == PWR_DOWN) && !gap;
			// exit placed on a clock edge
			CMD_SRX:                           cmd_ok = (pwr_state == PWR_SELF) && !gap;
			CMD_NOP:                           cmd_ok = on_ok && nop_permit;
			CMD_WR, CMD_WRA, CMD_RD, CMD_RDA:  cmd_ok = on_ok && (burst_cnt == 4'h0);
			CMD_RFU, CMD_DES:                  cmd_ok = 1'h0;
			default:                           cmd_ok = on_ok;
		endcase
	endfunction
	assign ok = cmd_ok(req_cmd);

	// command encoding on act_n, ras, cas, we
	function automatic logic [3:0] encode(input dcd_cmd_t c, input logic [2:0] row_hi);
		case (c)
			CMD_ACT:           encode = {1'h0, row_hi};
			CMD_MRS:           encode = 4'h8;
			CMD_REF, CMD_SRE:  encode = 4'h9;
			CMD_PRE, CMD_PREA: encode = 4'hA;
			CMD_WR, CMD_WRA:   encode = 4'hC;
			CMD_RD, CMD_RDA:   encode = 4'hD;
			CMD_ZQCL, CMD_ZQCS: encode = 4'hE;
			default:           encode = 4'hF;
		endcase
	endfunction
	assign enc = encode(req_cmd, req_addr[16:14]);

	// chop bit and defined auto-precharge level
	function automatic logic [ADDR_W-1:0] build_addr(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] r;
		r = a;
		if (req_cmd inside {CMD_PRE, CMD_PREA, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA,
			CMD_ZQCL, CMD_ZQCS})
			r[AP_BIT] = ap;
		if (is_burst)
			r[BC_BIT] = ~req_bc4;
		build_addr = r;
	endfunction
	assign addr_cmd = build_addr(req_addr[ADDR_W-1:0]);

	// ---------------------------------------------------------------
	// pins, placed at the falling link clock edge
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			link.cke  <= CKE_RST;
			link.cs_n <= 1'h1;
			{link.act_n, link.ras_n_a16, link.cas_n_a15, link.we_n_a14} <= 4'hF;
			{link.bg, link.ba, link.a17, link.addr} <= '0;
			link.odt  <= 1'h0;
		end
		else if (tick)
		begin
			// idle cycles deselect with all pins at defined levels
			link.cs_n <= !(take && !deselect);
			{link.act_n, link.ras_n_a16, link.cas_n_a15, link.we_n_a14} <=
				(take && !deselect) ? enc : 4'hF;
			link.bg   <= take && !deselect ? req_bg : '0;
			link.ba   <= take && !deselect ? req_ba : '0;
			// upper address low except on activate
			link.a17  <= take && (req_cmd == CMD_ACT) ? req_addr[17] : 1'h0;
			link.addr <= take && !deselect ? addr_cmd : '0;
			// clock enable steps for entry and exit
			if (take && cke_cmd)
				link.cke <= req_cmd inside {CMD_PDX, CMD_SRX};
			link.odt  <= odt_req && (pwr_state != PWR_SELF);
		end
	end

	// ---------------------------------------------------------------
	// controller state
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			link.reset_n <= RESET_N_RST;
			req_taken    <= 1'h0;
			req_refused  <= 1'h0;
			gap          <= 1'h0;
			burst_cnt    <= 4'h0;
			pwr_state    <= PWR_ON;
			bank_open    <= '0;
		end
		else
		begin
			// device reset held off in normal work
			link.reset_n <= ~dram_reset_req;
			req_taken    <= take;
			req_refused  <= tick && req_valid && !ok;
			if (tick)
			begin
				// one deselect cycle after any clock enable step
				gap       <= take && cke_cmd;
				burst_cnt <= (take && is_burst) ? burst_ck(req_bc4)
					: (burst_cnt == 4'h0) ? 4'h0 : burst_cnt - 4'h1;
			end
			if (take)
			begin
				bank_open <= bank_update(bank_open, req_cmd, {req_bg, req_ba});
				if (req_cmd == CMD_SRE)
					pwr_state <= PWR_SELF;
				else if (req_cmd == CMD_PDE)
					pwr_state <= PWR_DOWN;
				else if (req_cmd inside {CMD_PDX, CMD_SRX})
					pwr_state <= PWR_ON;
			end
		end
	end
endmodule

// File: hw/dcd_dram.sv
/*
 * dcd_dram: device end of the command link. Samples the link pins with ref_clk,
 * finds rising edges of the link clock and decodes one command per edge, keeping
 * bank, burst, power and termination state.
 * Assumes pins change half a link period away from the rising edge and that the
 * link clock runs well below a quarter of ref_clk.
 */
`timescale 1ns/1ps
module dcd_dram
	import dcd_pkg::*;
#(
	parameter int ROW_BITS = ROW_W,
	parameter int COL_BITS = COL_W
)
(
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                srst,
	// link from controller
	dcd_link_if.dram                 link,
	// decoded command
	output logic                     cmd_valid,
	output dcd_cmd_t                 cmd_code,
	output logic [BG_W-1:0]          cmd_bg,
	output logic [BA_W-1:0]          cmd_ba,
	output logic [ROW_BITS-1:0]      cmd_row,
	output logic [COL_BITS-1:0]      cmd_col,
	output logic                     cmd_bc4,
	output logic [MR_SEL_W-1:0]      mr_sel,
	output logic [ADDR_W-1:0]        mr_op,
	// device state
	output logic [NBANK-1:0]         bank_open,
	output logic                     burst_busy,
	output logic                     refresh_pulse,
	output dcd_pwr_t                 pwr_state,
	output logic                     odt_on
);
	// ---------------------------------------------------------------
	// reset
	// ---------------------------------------------------------------
	logic [1:0] rst_pipe;
	logic       rstn_int;

	// assert at once, release on the clock
	always_ff @(posedge ref_clk or negedge link.reset_n)
	begin
		if (!link.reset_n)
			rst_pipe <= 2'h0;
		else if (srst)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'h1};
	end
	assign rstn_int = rst_pipe[1];

	// ---------------------------------------------------------------
	// pin sampling
	// ---------------------------------------------------------------
	localparam int PIN_W = 9 + BG_W + BA_W + ADDR_W;

	logic [PIN_W-1:0]  pin_raw;
	logic [PIN_W-1:0]  pin_meta;
	logic [PIN_W-1:0]  pin_sync;
	logic              p_ck;
	logic              p_cke;
	logic              p_cs_n;
	logic              p_act_n;
	logic [2:0]        p_enc;
	logic [BG_W-1:0]   p_bg;
	logic [BA_W-1:0]   p_ba;
	logic              p_a17;
	logic [ADDR_W-1:0] p_addr;
	logic              p_odt;

	assign pin_raw = {link.ck, link.cke, link.cs_n, link.act_n, link.ras_n_a16,
		link.cas_n_a15, link.we_n_a14, link.bg, link.ba, link.a17, link.addr, link.odt};

	// clock and pins share one synchroniser so they stay aligned
	always_ff @(posedge ref_clk)
	begin
		pin_meta <= pin_raw;
		pin_sync <= pin_meta;
	end

	assign {p_ck, p_cke, p_cs_n, p_act_n, p_enc, p_bg, p_ba, p_a17, p_addr, p_odt} = pin_sync;

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	logic       ck_d;
	logic       cke_prev;
	logic       ck_rise;
	logic [1:0] bmode;
	dcd_cmd_t   cmd_now;

	assign ck_rise = p_ck && !ck_d;

	function automatic dcd_cmd_t decode_cmd(
		input logic       was_hi,
		input logic       is_hi,
		input dcd_pwr_t   pwr,
		input logic       cs_n,
		input logic       act_n,
		input logic [2:0] enc,
		input logic       ap
	);
		logic     nop_code;
		dcd_cmd_t c;
		nop_code = !cs_n && act_n && (enc == 3'h7);
		c = CMD_RFU;
		// clock enable history picks entry and exit
		if (!was_hi && !is_hi)
			c = CMD_DES;
		else if (!was_hi)
			// exit taken synchronously on the sampled edge
			c = (pwr == PWR_SELF && (cs_n || nop_code)) ? CMD_SRX
				: (pwr == PWR_DOWN && cs_n) ? CMD_PDX : CMD_RFU;
		else if (!is_hi)
			c = cs_n ? CMD_PDE : (act_n && enc == 3'h1) ? CMD_SRE : CMD_RFU;
		else if (cs_n)
			c = CMD_DES;
		else if (!act_n)
			c = CMD_ACT;
		else
		begin
			case (enc)
				3'h0:    c = CMD_MRS;
				3'h1:    c = CMD_REF;
				3'h2:    c = ap ? CMD_PREA : CMD_PRE;
				3'h4:    c = ap ? CMD_WRA : CMD_WR;
				3'h5:    c = ap ? CMD_RDA : CMD_RD;
				3'h6:    c = ap ? CMD_ZQCL : CMD_ZQCS;
				3'h7:    c = CMD_NOP;
				// reserved code decodes to no effect
				default: c = CMD_RFU;
			endcase
		end
		decode_cmd = c;
	endfunction

	// decode from the control pins and the auto-precharge bit, termination not among them
	assign cmd_now = decode_cmd(cke_prev, p_cke, pwr_state, p_cs_n, p_act_n, p_enc,
		p_addr[AP_BIT]);

	// ---------------------------------------------------------------
	// bank, burst and power tracking
	// ---------------------------------------------------------------
	logic [MR_SEL_W-1:0]   mr_sel_now;
	logic [BANK_IDX_W-1:0] bank_idx;
	logic [ROW_W-1:0]      row_now;
	logic                  bc4_now;
	logic                  is_burst;
	logic [3:0]            burst_cnt;
	logic [3:0]            burst_rem;
	logic [4:0]            burst_sum;
	logic [3:0]            next_burst;
	logic [NBANK-1:0]      next_banks;
	dcd_pwr_t              next_pwr;
	logic                  mrs_burst;
	logic                  refresh_ok;

	// bank select, or mode register select on a register write
	assign bank_idx   = {p_bg, p_ba};
	assign mr_sel_now = {p_bg[0], p_ba};
	// shared pins form the upper row bits
	assign row_now    = {p_a17, p_enc, p_addr};
	assign mrs_burst  = (cmd_now == CMD_MRS) && (mr_sel_now == MR_BURST);

	// chop pin counts only in on-the-fly mode
	assign bc4_now  = (bmode == BM_FIXED4) || ((bmode == BM_OTF) && !p_addr[BC_BIT]);
	assign is_burst = cmd_now inside {CMD_WR, CMD_WRA, CMD_RD, CMD_RDA};

	// a new burst queues behind the running one, never cuts it
	assign burst_rem  = (burst_cnt == 4'h0) ? 4'h0 : burst_cnt - 4'h1;
	assign burst_sum  = {1'h0, burst_rem} + {1'h0, burst_ck(bc4_now)};
	assign next_burst = !ck_rise ? burst_cnt
		: !is_burst ? burst_rem
		: burst_sum[4] ? 4'hF : burst_sum[3:0];

	// reserved codes fall through the map unchanged
	assign next_banks = (pwr_state == PWR_ON) ? bank_update(bank_open, cmd_now, bank_idx)
		: bank_open;

	assign next_pwr = (cmd_now == CMD_SRE) ? PWR_SELF
		: (cmd_now == CMD_PDE) ? PWR_DOWN
		: (cmd_now inside {CMD_SRX, CMD_PDX}) ? PWR_ON : pwr_state;

	assign refresh_ok = (cmd_now == CMD_REF) && (pwr_state == PWR_ON);

	always_ff @(posedge ref_clk or negedge rstn_int)
	begin
		if (!rstn_int)
		begin
			// high so a clock already up at release is not taken as an edge
			ck_d          <= 1'h1;
			cke_prev      <= CKE_RST;
			pwr_state     <= PWR_ON;
			bmode         <= BM_RST;
			burst_cnt     <= 4'h0;
			burst_busy    <= 1'h0;
			bank_open     <= '0;
			refresh_pulse <= 1'h0;
			odt_on        <= 1'h0;
		end
		else
		begin
			ck_d          <= p_ck;
			burst_cnt     <= next_burst;
			burst_busy    <= next_burst != 4'h0;
			refresh_pulse <= ck_rise && refresh_ok;
			if (ck_rise)
			begin
				cke_prev  <= p_cke;
				pwr_state <= next_pwr;
				bank_open <= next_banks;
				odt_on    <= p_odt && (next_pwr != PWR_SELF);
				if (mrs_burst)
					bmode <= p_addr[1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// decoded command outputs
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn_int)
	begin
		if (!rstn_int)
		begin
			cmd_valid <= 1'h0;
			cmd_code  <= CMD_DES;
			cmd_bg    <= '0;
			cmd_ba    <= '0;
			cmd_row   <= '0;
			cmd_col   <= '0;
			cmd_bc4   <= 1'h0;
			mr_sel    <= '0;
			mr_op     <= '0;
		end
		else
		begin
			cmd_valid <= ck_rise && (cmd_now != CMD_DES);
			if (ck_rise && (cmd_now != CMD_DES))
			begin
				cmd_code <= cmd_now;
				cmd_bg   <= p_bg;
				cmd_ba   <= p_ba;
				// widths cut to the configured field sizes
				cmd_row  <= row_now[ROW_BITS-1:0];
				cmd_col  <= p_addr[COL_BITS-1:0];
				cmd_bc4  <= bc4_now;
				mr_sel   <= mr_sel_now;
				mr_op    <= p_addr;
			end
		end
	end
endmodule

// File: testbench/dcd_assertions.sv
/*
 * dcd_assertions: checks on the command link pins driven by the controller end.
 * Assumes the controller runs with its default CK_DIV of 8 on ref_clk.
 */
`timescale 1ns/1ps
module dcd_assertions
	import dcd_pkg::*;
(
	// clock and reset
	input wire logic		ref_clk,
	input wire logic		srst,
	// link pins
	input wire logic		ck,
	input wire logic		reset_n,
	input wire logic		cke,
	input wire logic		cs_n,
	input wire logic		act_n,
	input wire logic		ras_n_a16,
	input wire logic		cas_n_a15,
	input wire logic		we_n_a14,
	input wire logic [BG_W-1:0]	bg,
	input wire logic [BA_W-1:0]	ba,
	input wire logic		a17,
	input wire logic [ADDR_W-1:0]	addr,
	input wire logic		odt
);
	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	wire logic	[2:0] enc;
	wire logic	cmd_sel;
	assign enc = {ras_n_a16, cas_n_a15, we_n_a14};
	assign cmd_sel = !cs_n && act_n;

	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (srst);

	// half link period is four ref_clk cycles
	sequence s_hi4; ck[*4] ##1 !ck; endsequence
	sequence s_lo4; !ck[*4] ##1 ck; endsequence

	property p_ck_high; $rose(ck) |-> s_hi4; endproperty
	property p_ck_low; $fell(ck) |-> s_lo4; endproperty
	property p_pins_move;
		$changed({cke, cs_n, act_n, enc, bg, ba, a17, addr}) |-> $fell(ck);
	endproperty
	property p_hold; $fell(cs_n) |-> (!cs_n)[*8]; endproperty
	property p_no_rfu; cmd_sel |-> enc != 3'h3; endproperty
	property p_a17; cmd_sel |-> !a17; endproperty
	property p_sre; ($fell(cke) && !cs_n) |-> act_n && enc == 3'h1; endproperty
	property p_exit; $rose(cke) |-> cs_n || (act_n && enc == 3'h7); endproperty
	property p_gap; $changed(cke) |-> ##8 cs_n; endproperty

	a_ck_high: assert property (p_ck_high) else $error("link clock high phase wrong");
	a_ck_low: assert property (p_ck_low) else $error("link clock low phase wrong");
	a_pins_move: assert property (p_pins_move) else $error("pins moved off ck fall");
	a_hold: assert property (p_hold) else $error("command shorter than link cycle");
	a_no_rfu: assert property (p_no_rfu) else $error("reserved code on link");
	a_a17: assert property (p_a17) else $error("upper row bit set outside activate");
	a_sre: assert property (p_sre) else $error("clock enable fall with bad code");
	a_exit: assert property (p_exit) else $error("clock enable rise with bad code");
	a_gap: assert property (p_gap) else $error("command right after enable step");
	// termination must be dropped one link cycle after self refresh entry
	property p_odt_sr; ($fell(cke) && !cs_n) |-> ##8 !odt; endproperty
	a_odt_sr: assert property (p_odt_sr) else $error("termination on in self refresh");
endmodule

// File: testbench/ddr_command_decoder_tb_top.sv
/*
 * ddr_command_decoder_tb_top: controller and device ends joined by the link.
 * Assumes default package geometry and CK_DIV of 8.
 */
`timescale 1ns/1ps
module ddr_command_decoder_tb_top;
	import dcd_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic			ref_clk, srst, req_valid, req_bc4, nop_permit;
	logic			odt_req, dram_reset_req, req_taken, req_refused;
	dcd_cmd_t		req_cmd, cmd_code;
	logic [BG_W-1:0]	req_bg, cmd_bg;
	logic [BA_W-1:0]	req_ba, cmd_ba;
	logic [ROW_W-1:0]	req_addr, cmd_row;
	dcd_pwr_t		c_pwr, d_pwr;
	logic [NBANK-1:0]	c_open, d_open;
	logic [COL_W-1:0]	cmd_col;
	logic [MR_SEL_W-1:0]	mr_sel;
	logic [ADDR_W-1:0]	mr_op;
	logic			cmd_valid, cmd_bc4, burst_busy, refresh_pulse, odt_on;
	int			n_errors, total_checks;
	localparam dcd_cmd_t CMDS [12] = '{CMD_ZQCL, CMD_ZQCS, CMD_REF, CMD_WR, CMD_RD,
		CMD_WRA, CMD_RDA, CMD_PRE, CMD_PREA, CMD_NOP, CMD_RFU, CMD_DES};

	dcd_link_if link_if ();
	dcd_ctrl u_dcd_ctrl (.ref_clk(ref_clk), .srst(srst), .link(link_if.ctrl),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_bg(req_bg), .req_ba(req_ba),
		.req_addr(req_addr), .req_bc4(req_bc4), .nop_permit(nop_permit),
		.odt_req(odt_req), .dram_reset_req(dram_reset_req), .req_taken(req_taken),
		.req_refused(req_refused), .pwr_state(c_pwr), .bank_open(c_open));
	dcd_dram u_dcd_dram (.ref_clk(ref_clk), .srst(srst), .link(link_if.dram),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bg(cmd_bg), .cmd_ba(cmd_ba),
		.cmd_row(cmd_row), .cmd_col(cmd_col), .cmd_bc4(cmd_bc4), .mr_sel(mr_sel),
		.mr_op(mr_op), .bank_open(d_open), .burst_busy(burst_busy),
		.refresh_pulse(refresh_pulse), .pwr_state(d_pwr), .odt_on(odt_on));
	dcd_assertions u_dcd_assertions (.ref_clk(ref_clk), .srst(srst), .ck(link_if.ck),
		.reset_n(link_if.reset_n), .cke(link_if.cke), .cs_n(link_if.cs_n),
		.act_n(link_if.act_n), .ras_n_a16(link_if.ras_n_a16),
		.cas_n_a15(link_if.cas_n_a15), .we_n_a14(link_if.we_n_a14), .bg(link_if.bg),
		.ba(link_if.ba), .a17(link_if.a17), .addr(link_if.addr), .odt(link_if.odt));

	always #12.5 ref_clk = ~ref_clk;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// bounded wait on the controller answer or the device decode pulse
	task automatic poll(input logic dev);
		int i;
		i = 0;
		while ((dev ? cmd_valid : (req_taken | req_refused)) !== 1'h1 && i < 40)
		begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		if ((dev ? cmd_valid : (req_taken | req_refused)) !== 1'h1)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
			complete_run;
		end
	endtask

	task automatic send(input dcd_cmd_t c, input logic [3:0] bk, input logic [17:0] a,
		input logic bc4, input logic ok, input int gap);
		@(negedge ref_clk);
		req_valid = 1'h1;
		req_cmd = c;
		{req_bg, req_ba} = bk;
		req_addr = a;
		req_bc4 = bc4;
		poll(1'h0);
		chk(req_taken, ok);
		@(negedge ref_clk);
		req_valid = 1'h0;
		if (ok)
		begin
			poll(1'h1);
			chk(cmd_code, c);
			chk(refresh_pulse, c == CMD_REF);
		end
		tick(gap);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_cmds;
		send(CMD_ACT, 4'h6, 18'h2ABCD, 1'h0, 1'h1, 8);
		chk(cmd_row, 18'h2ABCD);
		chk({cmd_bg, cmd_ba}, 4'h6);
		tick(2);
		chk(d_open, 16'h0040);
		chk(c_open, 16'h0040);
		send(CMD_MRS, 4'h3, 18'h00155, 1'h0, 1'h1, 8);
		chk(mr_sel, 3'h3);
		chk(mr_op, 14'h0155);
		for (int k = 0; k < 12; k++)
			send(CMDS[k], 4'h6, 18'h00010, 1'h0, k < 9, 48);
		nop_permit = 1'h1;
		send(CMD_NOP, 4'h0, 18'h00000, 1'h0, 1'h1, 48);
		nop_permit = 1'h0;
		$display("test cmds done");
	endtask

	task automatic t_burst;
		send(CMD_MRS, 4'h0, 18'h00001, 1'h0, 1'h1, 8);
		send(CMD_ACT, 4'h6, 18'h00100, 1'h0, 1'h1, 48);
		send(CMD_RD, 4'h6, 18'h00012, 1'h0, 1'h1, 0);
		chk(cmd_col, 10'h012);
		chk(cmd_bc4, 1'h0);
		send(CMD_WR, 4'h6, 18'h00000, 1'h0, 1'h0, 0);
		chk(burst_busy, 1'h1);
		tick(48);
		send(CMD_WR, 4'h6, 18'h00034, 1'h1, 1'h1, 48);
		chk(cmd_bc4, 1'h1);
		// fixed chop mode ignores the chop pin
		send(CMD_MRS, 4'h0, 18'h00002, 1'h0, 1'h1, 8);
		send(CMD_RD, 4'h6, 18'h00020, 1'h0, 1'h1, 48);
		chk(cmd_bc4, 1'h1);
		$display("test burst done");
	endtask

	task automatic t_power;
		send(CMD_SRE, 4'h0, 18'h00000, 1'h0, 1'h0, 48);
		send(CMD_PREA, 4'h0, 18'h00000, 1'h0, 1'h1, 48);
		odt_req = 1'h1;
		tick(16);
		chk(odt_on, 1'h1);
		send(CMD_SRE, 4'h0, 18'h00000, 1'h0, 1'h1, 48);
		chk(d_pwr, PWR_SELF);
		chk(c_pwr, PWR_SELF);
		chk(odt_on, 1'h0);
		send(CMD_REF, 4'h0, 18'h00000, 1'h0, 1'h0, 48);
		send(CMD_SRX, 4'h0, 18'h00000, 1'h0, 1'h1, 48);
		chk(d_pwr, PWR_ON);
		send(CMD_PDE, 4'h0, 18'h00000, 1'h0, 1'h1, 48);
		chk(d_pwr, PWR_DOWN);
		send(CMD_REF, 4'h0, 18'h00000, 1'h0, 1'h0, 48);
		send(CMD_PDX, 4'h0, 18'h00000, 1'h0, 1'h1, 48);
		chk(d_pwr, PWR_ON);
		chk(odt_on, 1'h1);
		odt_req = 1'h0;
		$display("test power done");
	endtask

	task automatic t_reset;
		send(CMD_ACT, 4'h2, 18'h00200, 1'h0, 1'h1, 8);
		dram_reset_req = 1'h1;
		tick(4);
		chk(link_if.reset_n, 1'h0);
		chk(d_open, 16'h0000);
		dram_reset_req = 1'h0;
		tick(8);
		// decode must resume cleanly after the device reset
		send(CMD_ACT, 4'h2, 18'h00200, 1'h0, 1'h1, 8);
		chk(d_open, 16'h0004);
		$display("test reset done");
	endtask

	initial
	begin
		ref_clk = 1'h0;
		srst = 1'h1;
		req_valid = 1'h0;
		req_cmd = CMD_DES;
		req_bg = 2'h0;
		req_ba = 2'h0;
		req_addr = 18'h00000;
		req_bc4 = 1'h0;
		nop_permit = 1'h0;
		odt_req = 1'h0;
		dram_reset_req = 1'h0;
		n_errors = 0;
		total_checks = 0;
		tick(20);
		srst = 1'h0;
		tick(8);
		chk(cmd_code, CMD_DES);
		chk(d_pwr, PWR_ON);
		t_cmds;
		t_burst;
		t_power;
		t_reset;
		complete_run;
	end
endmodule
